// ===== opstate_pkg.sv
// Constants, types and register map of the operating-state controller.
// Assumes one 25 MHz clock and an AXI4-Lite master with 32-bit data.
package opstate_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_BAUD = 4'h4;
  localparam logic [3:0] OFS_CMD = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hc;
  // Field positions
  localparam int CTRL_FWOK = 0;
  localparam int CMD_ARG = 3;
  localparam int CMD_TERM = 4;
  localparam int STAT_LOCK = 2;
  localparam int STAT_PIN = 3;
  localparam int STAT_FWOK = 6;
  // Baud codes and reset value
  localparam logic [1:0] BAUD_115K = 2'h0;
  localparam logic [1:0] BAUD_921K = 2'h1;
  localparam logic [1:0] BAUD_3M = 2'h2;
  localparam logic [1:0] BAUD_RST = BAUD_115K;
  // Command codes
  localparam logic [2:0] CMD_HOLD = 3'h1;
  localparam logic [2:0] CMD_SETUP = 3'h2;
  localparam logic [2:0] CMD_RLOAD = 3'h3;
  localparam logic [2:0] CMD_RST = 3'h4;
  // Announcement codes
  localparam logic [2:0] MSG_LOAD_IN = 3'h1;
  localparam logic [2:0] MSG_RUN_IN = 3'h2;
  localparam logic [2:0] MSG_RUN_OUT = 3'h3;
  localparam logic [2:0] MSG_SET_IN = 3'h4;
  localparam logic [2:0] MSG_SET_OUT = 3'h5;
  // AXI responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Timing
  localparam int CLK_KHZ = 25000;
  localparam int BOOT_WIN_MS = 3000;
  localparam int BOOT_WIN_CYC = BOOT_WIN_MS * CLK_KHZ;
  // Operating states
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_RUN = 2'b01,
    ST_CFG = 2'b10
  } op_state_t;
  // Announcement to the serial transmitter
  typedef struct packed {
    logic valid;
    logic [2:0] code;
    logic [1:0] baud;
  } msg_t;
endpackage

// ===== operating_state_controller.sv
// Operating-state controller: bootloader, run and setup sequencing.
// Assumes firmware feeds decoded serial commands through the CMD register
// and that trigger pin and pulse input arrive asynchronously.
`timescale 1ns/1ps
module operating_state_controller #(
  parameter int BOOT_WAIT_CYC = opstate_pkg::BOOT_WIN_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mode_trigger_n,
  input wire logic gnss_pulse_in,
  output opstate_pkg::op_state_t op_state,
  output logic [1:0] main_serial_baud,
  output logic rx_report_en,
  output logic settings_save,
  output opstate_pkg::msg_t announce,
  output logic one_second_pulse_out
);
  import opstate_pkg::*;

  // Bus handshake state
  logic aw_rdy_r, w_rdy_r, aw_got_r, w_got_r, bvalid_r, ar_rdy_r, rvalid_r;
  logic [3:0] awaddr_r; // Captured write address
  logic [31:0] wdata_r; // Captured write data
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic wr_do; // Both halves present
  // Software state
  logic fw_ok_r; // Integrity check result
  logic [1:0] edit_baud_r; // Baud edited in setup
  logic [1:0] stored_baud_r; // Committed baud
  logic cmd_stb_r; // One-cycle command strobe
  logic [2:0] cmd_code_r;
  logic cmd_arg_r;
  // Pin synchronisers
  logic pin_s1_r, pin_s2_r, sec_s1_r, sec_s2_r, sec_d_r;
  // Controller state
  op_state_t st_r, st_nxt;
  logic lock_r, lock_nxt;
  logic [31:0] win_r; // Boot window counter
  logic win_done;
  msg_t ann_r, pend_r, first_nxt, second_nxt;
  logic [1:0] baud_r;
  logic save_r, rx_en_r, sec_r;

  assign wr_do = aw_got_r && w_got_r && !bvalid_r;

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_r <= 1'b1;
      aw_got_r <= 1'b0;
      awaddr_r <= 4'h0;
    end else if (s_axi_awvalid && aw_rdy_r) begin
      aw_rdy_r <= 1'b0;
      aw_got_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_rdy_r <= 1'b1;
      aw_got_r <= 1'b0;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_rdy_r <= 1'b1;
      w_got_r <= 1'b0;
      wdata_r <= 32'h0;
    end else if (s_axi_wvalid && w_rdy_r) begin
      w_rdy_r <= 1'b0;
      w_got_r <= 1'b1;
      wdata_r <= s_axi_wdata;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_rdy_r <= 1'b1;
      w_got_r <= 1'b0;
    end
  end

  // Write response, unmapped or status writes answer error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OK;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r <= (awaddr_r == OFS_STAT || awaddr_r[1:0] != 2'h0) ? RESP_ERR : RESP_OK;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Control and baud registers, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fw_ok_r <= 1'b0;
      edit_baud_r <= BAUD_RST;
    end else if (wr_do && s_axi_wstrb[0]) begin
      if (awaddr_r == OFS_CTRL)
        fw_ok_r <= wdata_r[CTRL_FWOK];
      // Codes above 3 Mbps refused
      if (awaddr_r == OFS_BAUD && wdata_r[1:0] <= BAUD_3M)
        edit_baud_r <= wdata_r[1:0];
    end
  end

  // Command strobe, unterminated commands dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_stb_r <= 1'b0;
      cmd_code_r <= 3'h0;
      cmd_arg_r <= 1'b0;
    end else begin
      cmd_stb_r <= wr_do && s_axi_wstrb[0] && awaddr_r == OFS_CMD && wdata_r[CMD_TERM];
      cmd_code_r <= wdata_r[2:0];
      cmd_arg_r <= wdata_r[CMD_ARG];
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_rdy_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OK;
    end else if (s_axi_arvalid && ar_rdy_r) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OK;
      rdata_r <= 32'h0;
      unique case (s_axi_araddr)
        OFS_CTRL: rdata_r[CTRL_FWOK] <= fw_ok_r;
        OFS_BAUD: rdata_r[1:0] <= edit_baud_r;
        OFS_CMD: rdata_r <= 32'h0;
        OFS_STAT: begin
          rdata_r[1:0] <= st_r;
          rdata_r[STAT_LOCK] <= lock_r;
          rdata_r[STAT_PIN] <= pin_s2_r;
          rdata_r[5:4] <= baud_r;
          rdata_r[STAT_FWOK] <= fw_ok_r;
        end
        default: rresp_r <= RESP_ERR;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      ar_rdy_r <= 1'b1;
    end
  end

  // Two-stage synchronisers for pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      sec_s1_r <= 1'b0;
      sec_s2_r <= 1'b0;
      sec_d_r <= 1'b0;
    end else begin
      pin_s1_r <= mode_trigger_n;
      pin_s2_r <= pin_s1_r;
      sec_s1_r <= gnss_pulse_in;
      sec_s2_r <= sec_s1_r;
      sec_d_r <= sec_s2_r;
    end
  end

  // One-cycle pulse on each rising navigation edge
  always_ff @(posedge aclk) begin
    if (!aresetn)
      sec_r <= 1'b0;
    else
      sec_r <= sec_s2_r && !sec_d_r;
  end

  // Boot window counter, restarted on every bootloader entry
  always_ff @(posedge aclk) begin
    if (!aresetn || st_r != ST_BOOT)
      win_r <= 32'h0;
    else if (!win_done)
      win_r <= win_r + 32'h1;
  end
  assign win_done = win_r >= 32'(BOOT_WAIT_CYC - 1);

  // Next state, lock and announcements
  always_comb begin
    st_nxt = st_r;
    lock_nxt = lock_r;
    first_nxt = '0;
    second_nxt = '0;
    if (!pend_r.valid) begin
      unique case (st_r)
        ST_BOOT: begin
          if (cmd_stb_r && cmd_code_r == CMD_HOLD) begin
            lock_nxt = cmd_arg_r;
          end else if (win_done && pin_s2_r && !lock_r && fw_ok_r) begin
            // Leave only on released pin, no lock, good image
            st_nxt = ST_RUN;
            first_nxt = '{1'b1, MSG_RUN_IN, stored_baud_r};
          end
        end
        ST_RUN: begin
          if (!pin_s2_r || (cmd_stb_r && cmd_code_r == CMD_SETUP && cmd_arg_r)) begin
            st_nxt = ST_CFG;
            lock_nxt = pin_s2_r; // Command entry also locks
            first_nxt = '{1'b1, MSG_RUN_OUT, stored_baud_r};
            second_nxt = '{1'b1, MSG_SET_IN, BAUD_115K};
          end
        end
        ST_CFG: begin
          if (cmd_stb_r && cmd_code_r == CMD_HOLD) begin
            lock_nxt = cmd_arg_r;
          end else if (cmd_stb_r && (cmd_code_r == CMD_RLOAD || cmd_code_r == CMD_RST)) begin
            st_nxt = ST_BOOT;
            lock_nxt = cmd_code_r == CMD_RLOAD;
            first_nxt = '{1'b1, MSG_SET_OUT, BAUD_115K};
            second_nxt = '{1'b1, MSG_LOAD_IN, BAUD_115K};
          end else if ((pin_s2_r && !lock_r) || (cmd_stb_r && cmd_code_r == CMD_SETUP && !cmd_arg_r)) begin
            st_nxt = ST_RUN;
            lock_nxt = 1'b0;
            first_nxt = '{1'b1, MSG_SET_OUT, BAUD_115K};
            second_nxt = '{1'b1, MSG_RUN_IN, edit_baud_r};
          end
        end
        default: st_nxt = ST_BOOT;
      endcase
    end
  end

  // State and lock registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_BOOT;
      lock_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      lock_r <= lock_nxt;
    end
  end

  // Announcement pair, second one follows a cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ann_r <= '{1'b1, MSG_LOAD_IN, BAUD_115K};
      pend_r <= '0;
    end else if (pend_r.valid) begin
      ann_r <= pend_r;
      pend_r <= '0;
    end else begin
      ann_r <= first_nxt;
      pend_r <= second_nxt;
    end
  end

  // Committed settings and save pulse on setup exit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stored_baud_r <= BAUD_RST;
      save_r <= 1'b0;
    end else begin
      save_r <= st_r == ST_CFG && st_nxt != ST_CFG;
      if (st_r == ST_CFG && st_nxt != ST_CFG)
        stored_baud_r <= edit_baud_r;
    end
  end

  // Serial rate and reception follow the state being entered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud_r <= BAUD_115K;
      rx_en_r <= 1'b0;
    end else begin
      baud_r <= (st_nxt == ST_RUN) ? ((st_r == ST_CFG) ? edit_baud_r : stored_baud_r) : BAUD_115K;
      rx_en_r <= st_nxt == ST_RUN;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = aw_rdy_r;
  assign s_axi_wready = w_rdy_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ar_rdy_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign op_state = st_r;
  assign main_serial_baud = baud_r;
  assign rx_report_en = rx_en_r;
  assign settings_save = save_r;
  assign announce = ann_r;
  assign one_second_pulse_out = sec_r;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_boot: assert property ($past(!aresetn) |-> st_r == ST_BOOT && !lock_r)
    else $error("not in bootloader after reset");
  a_fixed_rate: assert property (st_r != ST_RUN |-> baud_r == BAUD_115K)
    else $error("non-run state off fixed rate");
  a_setup_quiet: assert property (st_r != ST_RUN |-> !rx_en_r)
    else $error("reporting outside run state");
  a_pin_hold: assert property (st_r == ST_BOOT && !pin_s2_r |=> st_r == ST_BOOT)
    else $error("left bootloader with pin low");
  a_fw_hold: assert property (st_r == ST_BOOT && !fw_ok_r |=> st_r == ST_BOOT)
    else $error("left bootloader with bad image");
  a_run_msg: assert property ($rose(st_r == ST_RUN) |-> ##[0:1] (ann_r.valid && ann_r.code == MSG_RUN_IN))
    else $error("no run entry message");
  a_run_rate: assert property (st_r == ST_RUN |-> baud_r == stored_baud_r && rx_en_r)
    else $error("run rate not stored value");
  a_setup_pair: assert property ($rose(st_r == ST_CFG) |-> ann_r.code == MSG_RUN_OUT ##1
    (ann_r.code == MSG_SET_IN && ann_r.baud == BAUD_115K))
    else $error("bad setup entry messages");
  a_commit_save: assert property ($fell(st_r == ST_CFG) |-> save_r)
    else $error("no save on setup exit");
  a_setup_exit: assert property ($fell(st_r == ST_CFG) |-> ann_r.valid && ann_r.code == MSG_SET_OUT
    && ann_r.baud == BAUD_115K)
    else $error("bad setup exit message");
  a_loader_msg: assert property ($rose(st_r == ST_BOOT) |-> ##[0:1] (ann_r.code == MSG_LOAD_IN))
    else $error("no loader entry message");
  a_setup_lock: assert property (st_r == ST_CFG && lock_r && !cmd_stb_r && !pend_r.valid |=> st_r == ST_CFG)
    else $error("locked setup state left");
  a_pulse_out: assert property (sec_s2_r && !sec_d_r |=> one_second_pulse_out ##1 !one_second_pulse_out)
    else $error("pulse output wrong");

  c_boot_run: cover property (st_r == ST_BOOT ##1 st_r == ST_RUN);
  c_run_cfg: cover property (st_r == ST_RUN ##1 st_r == ST_CFG);
  c_cfg_boot: cover property (st_r == ST_CFG ##1 st_r == ST_BOOT && lock_r);
endmodule

// ===== host_pins.sv
// Host model: drives the mode trigger pin and the navigation pulse.
// Assumes the bench asks for pin levels on its own clock.
`timescale 1ns/1ps
module host_pins (
  input wire logic aclk,
  input wire logic hold_req,
  input wire logic pulse_req,
  output logic mode_trigger_n,
  output logic gnss_pulse_in
);
  // Trigger pin held low and pulse idle low at time zero
  initial begin
    mode_trigger_n = 1'b0;
    gnss_pulse_in = 1'b0;
  end
  // Pin low while the host holds or switches state
  always @(posedge aclk) begin
    mode_trigger_n <= ~hold_req;
    gnss_pulse_in <= pulse_req;
  end
endmodule

// ===== tb.sv
// Self-checking bench for the operating-state controller.
// Assumes opstate_pkg and host_pins are compiled first.
`timescale 1ns/1ps
module tb;
  import opstate_pkg::*;
  localparam int WAIT_CYC = 20;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, mode_trigger_n, gnss_pulse_in;
  logic rx_report_en, settings_save, one_second_pulse_out, hold_req, pulse_req;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd;
  logic [1:0] s_axi_bresp, s_axi_rresp, main_serial_baud, eb;
  op_state_t op_state;
  msg_t announce;
  logic [4:0] exp_q[$]; // Expected {code, baud}
  int n_fail, check_count, n_save, n_sec;
  operating_state_controller #(.BOOT_WAIT_CYC(WAIT_CYC)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mode_trigger_n, .gnss_pulse_in, .op_state, .main_serial_baud, .rx_report_en, .settings_save,
    .announce, .one_second_pulse_out
  );
  host_pins partner (.aclk, .hold_req, .pulse_req, .mode_trigger_n, .gnss_pulse_in);
  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Bounded hang guard
  initial begin
    repeat (6000) @(posedge aclk);
    n_fail++;
    print_verdict;
  end
  // Announcement watcher takes the oldest note
  always @(posedge aclk) begin
    if (aresetn === 1'b1 && announce.valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk({announce.code, announce.baud}, exp_q.pop_front());
    end
    if (settings_save === 1'b1) n_save++;
    if (one_second_pulse_out === 1'b1) n_sec++;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [31:0] cmd(input logic [2:0] c, input logic a, input logic t);
    return {27'h0, t, a, c};
  endfunction
  // Note two announcements
  task automatic ex2(input logic [2:0] c1, input logic [1:0] b1, input logic [2:0] c2, input logic [1:0] b2);
    exp_q.push_back({c1, b1});
    exp_q.push_back({c2, b2});
  endtask
  // AXI4-Lite write, address and data together
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    chk(n < 100, 1);
  endtask
  // AXI4-Lite read
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk({s_axi_rresp, n < 100}, {er, 1'b1});
  endtask
  // Wait until every noted announcement arrived
  task automatic wm;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    chk(exp_q.size(), 0);
    repeat (3) @(posedge aclk);
  endtask
  task automatic st(input op_state_t s, input logic r, input logic [1:0] b);
    chk({op_state, rx_report_en, main_serial_baud}, {s, r, b});
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    exp_q.push_back({MSG_LOAD_IN, BAUD_115K});
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  // Main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pulse_req} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    hold_req = 1'b1;
    aresetn = 1'b0;
    {n_fail, check_count, n_save, n_sec} = 128'h0;
    rnd = 32'h0000000b;
    eb = BAUD_115K;
    do_reset;
    wr(OFS_CTRL, 32'h1, RESP_OK);
    repeat (2 * WAIT_CYC) @(posedge aclk);
    wm;
    st(ST_BOOT, 1'b0, BAUD_115K);
    exp_q.push_back({MSG_RUN_IN, BAUD_115K});
    hold_req <= 1'b0;
    wm;
    st(ST_RUN, 1'b1, BAUD_115K);
    rd(OFS_STAT, 32'h49, RESP_OK);
    $display("test boot_release done");
    ex2(MSG_RUN_OUT, eb, MSG_SET_IN, BAUD_115K);
    wr(OFS_CMD, cmd(CMD_SETUP, 1'b1, 1'b1), RESP_OK);
    wm;
    st(ST_CFG, 1'b0, BAUD_115K);
    for (int i = 0; i < 4; i++) begin
      rnd = xs(rnd);
      wr(OFS_BAUD, {30'h0, rnd[1:0]}, RESP_OK);
      if (rnd[1:0] != 2'h3) eb = rnd[1:0];
      rd(OFS_BAUD, {30'h0, eb}, RESP_OK);
    end
    wr(OFS_CMD, cmd(CMD_SETUP, 1'b0, 1'b0), RESP_OK);
    repeat (6) @(posedge aclk);
    st(ST_CFG, 1'b0, BAUD_115K);
    ex2(MSG_SET_OUT, BAUD_115K, MSG_RUN_IN, eb);
    wr(OFS_CMD, cmd(CMD_SETUP, 1'b0, 1'b1), RESP_OK);
    wm;
    st(ST_RUN, 1'b1, eb);
    chk(n_save, 1);
    $display("test setup_command done");
    ex2(MSG_RUN_OUT, eb, MSG_SET_IN, BAUD_115K);
    hold_req <= 1'b1;
    wm;
    st(ST_CFG, 1'b0, BAUD_115K);
    ex2(MSG_SET_OUT, BAUD_115K, MSG_RUN_IN, eb);
    hold_req <= 1'b0;
    wm;
    st(ST_RUN, 1'b1, eb);
    chk(n_save, 2);
    $display("test setup_pin done");
    ex2(MSG_RUN_OUT, eb, MSG_SET_IN, BAUD_115K);
    hold_req <= 1'b1;
    wm;
    ex2(MSG_SET_OUT, BAUD_115K, MSG_LOAD_IN, BAUD_115K);
    wr(OFS_CMD, cmd(CMD_RLOAD, 1'b0, 1'b1), RESP_OK);
    wm;
    hold_req <= 1'b0;
    repeat (2 * WAIT_CYC) @(posedge aclk);
    st(ST_BOOT, 1'b0, BAUD_115K);
    exp_q.push_back({MSG_RUN_IN, eb});
    wr(OFS_CMD, cmd(CMD_HOLD, 1'b0, 1'b1), RESP_OK);
    wm;
    st(ST_RUN, 1'b1, eb);
    $display("test loader_lock done");
    ex2(MSG_RUN_OUT, eb, MSG_SET_IN, BAUD_115K);
    hold_req <= 1'b1;
    wm;
    ex2(MSG_SET_OUT, BAUD_115K, MSG_LOAD_IN, BAUD_115K);
    wr(OFS_CMD, cmd(CMD_RST, 1'b0, 1'b1), RESP_OK);
    wm;
    wr(OFS_CMD, cmd(CMD_HOLD, 1'b1, 1'b1), RESP_OK);
    hold_req <= 1'b0;
    repeat (2 * WAIT_CYC) @(posedge aclk);
    rd(OFS_STAT, 32'h4c, RESP_OK);
    $display("test hold_command done");
    wr(4'h1, 32'h1, RESP_ERR);
    wr(OFS_STAT, 32'h1, RESP_ERR);
    rd(4'h2, 32'h0, RESP_ERR);
    repeat (2) begin
      pulse_req <= 1'b1;
      repeat (3) @(posedge aclk);
      pulse_req <= 1'b0;
      repeat (6) @(posedge aclk);
    end
    chk(n_sec, 2);
    $display("test bus_and_pulse done");
    do_reset;
    wm;
    rd(OFS_STAT, 32'h08, RESP_OK);
    repeat (2 * WAIT_CYC) @(posedge aclk);
    st(ST_BOOT, 1'b0, BAUD_115K);
    $display("test second_reset done");
    print_verdict;
  end
endmodule
